//--- hw/gtc_chan_if.sv
// bundle between the register/pin top and one counter channel
// assumes both ends run on mclk
`timescale 1ns/1ps
interface gtc_chan_if;
  import gtc_pkg::*;
  gtc_mode_e mode;
  gtc_clk_e clk_sel;
  logic gate_en;
  logic gate_hi;
  logic evt_src;
  logic run;
  logic wr_stb;
  logic [CNT_W-1:0] wdata;
  logic en_f8;
  logic en_f32;
  logic pin_level;
  logic pin_rise;
  logic prev_uf;
  logic [CNT_W-1:0] count;
  logic uf;
  logic done;
  logic tog;
  modport ctrl (output mode, clk_sel, gate_en, gate_hi, evt_src, run, wr_stb, wdata,
    en_f8, en_f32, pin_level, pin_rise, prev_uf, input count, uf, done, tog);
  modport chan (input mode, clk_sel, gate_en, gate_hi, evt_src, run, wr_stb, wdata,
    en_f8, en_f32, pin_level, pin_rise, prev_uf, output count, uf, done, tog);
endinterface : gtc_chan_if

//--- hw/gtc_channel.sv
// one 16-bit down counter with reload register and pulse toggle
// assumes pin inputs already synchronised and count enables one mclk wide
`timescale 1ns/1ps
module gtc_channel
  import gtc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  gtc_chan_if.chan ch
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] reload;
  logic tog;
  logic uf;
  logic done;
  logic presc_en;
  logic gate_ok;
  logic tick;

  always_comb begin
    unique case (ch.clk_sel)
      CLK_F1: presc_en = 1'b1; // [RULE5]
      CLK_F8: presc_en = ch.en_f8; // [RULE5]
      CLK_F32, CLK_RSV: presc_en = ch.en_f32; // [RULE5]
    endcase
  end

  // gate compares the pin with the chosen active level
  assign gate_ok = !ch.gate_en || (ch.pin_level == ch.gate_hi); // [RULE13] [RULE15]
  assign tick = (ch.mode == MODE_EVENT) ?
    (ch.run && (ch.evt_src ? ch.prev_uf : ch.pin_rise)) : // [RULE4]
    // done holds off the tick until START drops; a second halt pulse would toggle the pin back
    (ch.run && presc_en && gate_ok && !done); // [RULE3] [RULE7] [RULE8]

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= COUNT_RST;
      reload <= COUNT_RST;
      uf <= 1'b0;
      done <= 1'b0;
    end else begin
      uf <= 1'b0;
      done <= 1'b0;
      if (tick) begin
        if (ch.mode == MODE_ONESHOT) begin
          if (cnt <= 16'h0001) begin
            cnt <= COUNT_RST; // [RULE3]
            done <= 1'b1; // [RULE3]
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end else if (cnt == COUNT_RST) begin
          cnt <= reload; // [RULE6]
          uf <= 1'b1; // [RULE9]
        end else begin
          cnt <= cnt - 16'h0001; // [RULE6]
        end
      end
      if (ch.wr_stb) begin
        reload <= ch.wdata; // [RULE11] [RULE12]
        if (!ch.run) begin
          cnt <= ch.wdata; // [RULE11]
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tog <= 1'b0;
    end else if (uf || done) begin
      tog <= ~tog; // [RULE14]
    end
  end

  assign ch.count = cnt; // [RULE10]
  assign ch.uf = uf;
  assign ch.done = done;
  assign ch.tog = tog;
endmodule : gtc_channel

//--- hw/gtc_pkg.sv
// constants, field layout and mode types for the five-channel down-counting timer group
// assumes a single 100 MHz peripheral clock and an APB register slave in front of it
// Functional notes
// RULE1: five 16-bit timer channels, each independent except that event mode can count the previous channel's underflows.
// RULE2: two lowest mode register bits pick timer, event, one-shot or pulse-width mode; code 3 (MODE_PWM) runs as timer mode here.
// RULE3: one-shot mode halts counting once the counter reaches zero.
// RULE4: event mode counts input pin edges or the previous channel's underflows.
// RULE5: timer mode counts the peripheral clock divided by one, eight or thirty-two.
// RULE6: counter decrements and reloads on underflow, dividing by reload plus one.
// RULE7: setting the count-start bit starts counting.
// RULE8: clearing the count-start bit stops counting.
// RULE9: every underflow in timer mode raises the channel interrupt request.
// RULE10: reading the count register returns the live counter value.
// RULE11: writing the count register while stopped loads reload and counter.
// RULE12: writing while counting loads only reload; counter takes it at next reload.
// RULE13: with gate selected, the input pin level starts and stops counting.
// RULE14: with pulse output selected, the output pin toggles on every underflow.
// RULE15: input pin serves as general port input or as gate input.
// RULE16: output pin serves as general port output or as toggling pulse output.
// RULE17: mode, clock select and gate level encodings are fixed in this package.
// RULE18: interrupt requests are sticky status bits cleared by software reading them.
package gtc_pkg;
  localparam int NUM_CHAN = 5;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_START = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PORT_OUT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PORT_IN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] CHAN_STRIDE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;

  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int PULSE_BIT = 2;
  localparam int GATE_EN_BIT = 3;
  localparam int GATE_HI_BIT = 4;
  localparam int EVT_SRC_BIT = 5;
  localparam int CLKSEL_LSB = 6;
  localparam int MODE_REG_W = 8;

  localparam logic [MODE_REG_W-1:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [NUM_CHAN-1:0] BITS_RST = 5'h00;

  // prescaler: f8 and f32 enables from one free-running 5-bit counter
  localparam int PRESC_W = 5;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [PRESC_W-1:0] DIV32_LAST = 5'h1F;

  typedef enum logic [1:0] {MODE_TIMER, MODE_EVENT, MODE_ONESHOT, MODE_PWM} gtc_mode_e;
  typedef enum logic [1:0] {CLK_F1, CLK_F8, CLK_F32, CLK_RSV} gtc_clk_e;
endpackage : gtc_pkg

//--- hw/gtc_top.sv
// five timer channels behind an APB slave, with prescaler, pin functions and interrupt
// assumes APB master on mclk; gate pins are asynchronous and synchronised here
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gtc_top
  import gtc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CHAN-1:0] channel_gate_input_pin,
  output logic [NUM_CHAN-1:0] channel_pulse_output_pin,
  output logic irq
);
  logic [NUM_CHAN-1:0] start;
  logic [NUM_CHAN-1:0] irq_stat;
  logic [NUM_CHAN-1:0] irq_mask;
  logic [NUM_CHAN-1:0] port_out;
  logic [MODE_REG_W-1:0] mode_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0] pin_meta;
  logic [NUM_CHAN-1:0] pin_sync;
  logic [NUM_CHAN-1:0] pin_dly;
  logic [PRESC_W-1:0] presc;
  logic en_f8;
  logic en_f32;
  logic [NUM_CHAN-1:0] uf_vec;
  logic [NUM_CHAN-1:0] done_vec;
  logic [NUM_CHAN-1:0] tog_vec;
  logic [CNT_W-1:0] count_vec [NUM_CHAN];
  logic setup;
  logic access;
  logic wr;
  logic [31:0] next_rdata;
  logic next_err;
  logic err_q;
  logic [NUM_CHAN-1:0] rd_clr;
  logic [NUM_CHAN-1:0] next_rd_clr;
  logic [ADDR_W-1:0] chan_rel;
  logic [2:0] chan_idx;
  logic chan_hit;
  logic [NUM_CHAN-1:0] evt_vec;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && err_q;

  // channel window decode: stride 8, mode then count
  assign chan_rel = paddr - ADDR_CHAN_BASE;
  assign chan_idx = chan_rel[5:3];
  assign chan_hit = (paddr >= ADDR_CHAN_BASE) && (chan_idx < 3'(NUM_CHAN)) &&
    (chan_rel[1:0] == 2'b00) && (paddr < ADDR_CHAN_BASE + 8'(NUM_CHAN) * CHAN_STRIDE);

  // three flops per pin; the second stage feeds logic, the third only the rise detect
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_meta <= BITS_RST;
      pin_sync <= BITS_RST;
      pin_dly <= BITS_RST;
    end else begin
      pin_meta <= channel_gate_input_pin;
      pin_sync <= pin_meta;
      pin_dly <= pin_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      presc <= '0;
    end else begin
      presc <= presc + 5'h01;
    end
  end
  assign en_f8 = (presc[2:0] == DIV8_LAST); // [RULE5]
  assign en_f32 = (presc == DIV32_LAST); // [RULE5]

  // read data and error are latched in the setup cycle so prdata comes from a flop
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    next_rd_clr = '0;
    if (chan_hit) begin
      if (chan_rel[2:0] == OFS_MODE[2:0]) begin
        next_rdata = {24'h00_0000, mode_reg[chan_idx]};
      end else begin
        next_rdata = {16'h0000, count_vec[chan_idx]}; // [RULE10]
      end
    end else begin
      unique case (paddr)
        ADDR_START: next_rdata = {27'h0, start};
        ADDR_IRQ_STAT: begin
          next_rdata = {27'h0, irq_stat};
          next_rd_clr = pwrite ? '0 : irq_stat; // [RULE18]
        end
        ADDR_IRQ_MASK: next_rdata = {27'h0, irq_mask};
        ADDR_PORT_OUT: next_rdata = {27'h0, port_out};
        ADDR_PORT_IN: next_rdata = {27'h0, pin_sync}; // [RULE15]
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
      rd_clr <= '0;
    end else if (setup) begin
      prdata <= next_rdata;
      err_q <= next_err;
      rd_clr <= next_rd_clr;
    end
  end

  // software write to the start register wins over a one-shot halt in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      start <= BITS_RST;
    end else if (wr && !err_q && paddr == ADDR_START) begin
      start <= pwdata[NUM_CHAN-1:0]; // [RULE7] [RULE8]
    end else begin
      start <= start & ~done_vec; // [RULE3]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_mask <= BITS_RST;
      port_out <= BITS_RST;
    end else if (wr) begin
      if (paddr == ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[NUM_CHAN-1:0];
      end
      if (paddr == ADDR_PORT_OUT) begin
        port_out <= pwdata[NUM_CHAN-1:0];
      end
    end
  end

  // only bits seen by the read are cleared, and a new event in the clear cycle stays set
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat <= BITS_RST;
    end else begin
      irq_stat <= (irq_stat & ~((access && !pwrite) ? rd_clr : '0)) | uf_vec | done_vec; // [RULE9] [RULE18]
    end
  end
  assign irq = |(irq_stat & irq_mask); // [RULE18]

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    gtc_chan_if ch_if ();
    logic mode_wr;
    logic count_wr;

    assign mode_wr = wr && chan_hit && (chan_idx == 3'(i)) && (chan_rel[2:0] == OFS_MODE[2:0]);
    assign count_wr = wr && chan_hit && (chan_idx == 3'(i)) && (chan_rel[2:0] == OFS_COUNT[2:0]);

    always_ff @(posedge mclk) begin
      if (srst) begin
        mode_reg[i] <= MODE_RST;
      end else if (mode_wr) begin
        mode_reg[i] <= pwdata[MODE_REG_W-1:0];
      end
    end

    assign ch_if.mode = gtc_mode_e'(mode_reg[i][MODE_LSB+:2]); // [RULE2] [RULE17]
    assign ch_if.clk_sel = gtc_clk_e'(mode_reg[i][CLKSEL_LSB+:2]); // [RULE17]
    assign ch_if.gate_en = mode_reg[i][GATE_EN_BIT]; // [RULE13]
    assign ch_if.gate_hi = mode_reg[i][GATE_HI_BIT]; // [RULE17]
    assign ch_if.evt_src = mode_reg[i][EVT_SRC_BIT]; // [RULE4]
    assign ch_if.run = start[i]; // [RULE7] [RULE8]
    assign ch_if.wr_stb = count_wr; // [RULE11] [RULE12]
    assign ch_if.wdata = pwdata[CNT_W-1:0];
    assign ch_if.en_f8 = en_f8;
    assign ch_if.en_f32 = en_f32;
    assign ch_if.pin_level = pin_sync[i];
    assign ch_if.pin_rise = pin_sync[i] && !pin_dly[i];
    // ring: channel 0 takes channel 4's underflow
    assign ch_if.prev_uf = uf_vec[(i + NUM_CHAN - 1) % NUM_CHAN]; // [RULE4]
    assign uf_vec[i] = ch_if.uf;
    assign done_vec[i] = ch_if.done;
    assign tog_vec[i] = ch_if.tog;
    assign count_vec[i] = ch_if.count;
    assign evt_vec[i] = mode_reg[i][PULSE_BIT];

    gtc_channel u_chan (
      .mclk(mclk),
      .srst(srst),
      .ch(ch_if.chan)
    ); // [RULE1]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      channel_pulse_output_pin <= BITS_RST;
    end else begin
      channel_pulse_output_pin <= (evt_vec & tog_vec) | (~evt_vec & port_out); // [RULE14] [RULE16]
    end
  end
endmodule : gtc_top

//--- sim/gtc_pin_model.sv
// stand-in for the outside circuit that drives the channel gate pins
// assumes the bench asks for pin levels in step with mclk
`timescale 1ns/1ps
module gtc_pin_model (
  input wire logic mclk,
  input wire logic [4:0] lvl,
  output logic [4:0] gate
);
  logic [4:0] pin_q = 5'h00;
  // levels move only at edges, so every step reaches the synchroniser cleanly
  always @(posedge mclk) pin_q <= lvl;
  assign gate = pin_q;
endmodule : gtc_pin_model

//--- sim/gtc_top_checker.sv
// port-level checks on the timer group's APB face, pins and interrupt
// assumes one mclk domain with srst synchronous, active high
`timescale 1ns/1ps
module gtc_top_checker
  import gtc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] channel_gate_input_pin,
  input wire logic [4:0] channel_pulse_output_pin,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_mask_off;
    psel && penable && pwrite && paddr == ADDR_IRQ_MASK && pwdata[4:0] == 5'h00;
  endsequence
  sequence s_hole;
    psel && penable && paddr == 8'h14;
  endsequence
  a_ready_const: assert property (pready)
    else $error("pready low");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && !channel_pulse_output_pin)
    else $error("outputs not quiet after reset");
  a_mask_irq: assert property (s_mask_off |=> !irq)
    else $error("irq high with all masked");
  a_hole_err: assert property (s_hole |-> pslverr)
    else $error("no error on hole");
  a_start_ok: assert property (psel && penable && paddr == ADDR_START |-> !pslverr)
    else $error("error on start reg");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  a_misalign_err: assert property (psel && penable && paddr >= 8'h20 && paddr < 8'h48
    && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no error on misaligned access");
endmodule : gtc_top_checker

bind gtc_top gtc_top_checker u_chk (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .channel_gate_input_pin(channel_gate_input_pin),
  .channel_pulse_output_pin(channel_pulse_output_pin), .irq(irq));

//--- sim/tb_top.sv
// self-checking bench: register traffic and pin behaviour of the timer group
// assumes gtc_top with its bound checker; gate pins come from the pin model
`timescale 1ns/1ps
module tb_top;
  import gtc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, hold;
  logic pready, pslverr, irq, err;
  logic [4:0] lvl = 5'h00, gate, pout;
  int n_errors = 0, cmp_count = 0, c;
  int dv[3] = '{1, 8, 32};
  always #5 mclk = ~mclk;
  gtc_top uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_gate_input_pin(gate), .channel_pulse_output_pin(pout), .irq(irq));
  gtc_pin_model pm (.mclk(mclk), .lvl(lvl), .gate(gate));
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, pready);
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps the next request from driving psel twice in a step
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic gap();
    logic p;
    p = pout[0];
    c = 0;
    while (pout[0] === p && c < 2000) begin
      @(posedge mclk);
      c++;
    end
    if (c >= 2000) begin
      chk("pin_wait", 32'h0, 32'h1);
      summarize();
    end
  endtask : gap
  task automatic t_reset();
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24};
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset_val", 32'h0, q);
    end
    rd(8'h14);
    chk("hole_err", 32'h1, err);
    rd(8'h21);
    chk("misalign_err", 32'h1, err);
  endtask : t_reset
  task automatic t_period();
    for (int k = 0; k < 3; k++) begin
      // last pass uses the spare clock code and the pwm mode code, both acting as timer f32
      wr(8'h20, (k == 2) ? 32'hC7 : (32'h4 | (k << 6)));
      wr(8'h24, 32'h3);
      wr(ADDR_IRQ_MASK, 32'h1F);
      wr(ADDR_START, 32'h1);
      gap();
      gap();
      chk("period", 4 * dv[k], c);
      chk("irq", 32'h1, irq);
      rd(ADDR_IRQ_STAT);
      chk("stat", 32'h1, q);
      wr(ADDR_START, 32'h0);
      rd(8'h24);
      hold = q;
      repeat (70) @(posedge mclk);
      rd(8'h24);
      chk("stopped", hold, q);
      rd(ADDR_IRQ_STAT);
      rd(ADDR_IRQ_STAT);
      chk("stat_clr", 32'h0, q);
    end
    rd(8'h2C);
    chk("other_chan", 32'h0, q);
  endtask : t_period
  task automatic t_irq();
    wr(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_START, 32'h1);
    repeat (200) @(posedge mclk);
    chk("masked_irq", 32'h0, irq);
    wr(ADDR_IRQ_MASK, 32'h1);
    chk("unmasked_irq", 32'h1, irq);
    wr(ADDR_START, 32'h0);
  endtask : t_irq
  task automatic t_run();
    wr(8'h24, 32'hABCD);
    rd(8'h24);
    chk("stopped_wr", 32'hABCD, q);
    wr(8'h24, 32'h3);
    wr(ADDR_START, 32'h1);
    // writing just after an underflow keeps clear of the reload edge
    gap();
    wr(8'h24, 32'h9);
    gap();
    gap();
    chk("reload_wr", 32'h140, c);
    wr(ADDR_START, 32'h0);
  endtask : t_run
  task automatic t_gate();
    wr(8'h28, 32'h18);
    wr(8'h2C, 32'h64);
    wr(ADDR_START, 32'h2);
    repeat (20) @(posedge mclk);
    rd(8'h2C);
    chk("gate_closed", 32'h64, q);
    lvl <= 5'h02;
    repeat (20) @(posedge mclk);
    rd(8'h2C);
    chk("gate_open", 32'h1, q < 32'h64);
    rd(ADDR_PORT_IN);
    chk("port_in", 32'h2, q);
    wr(8'h28, 32'h8);
    rd(8'h2C);
    hold = q;
    repeat (10) @(posedge mclk);
    rd(8'h2C);
    chk("gate_low", hold, q);
    wr(ADDR_START, 32'h0);
  endtask : t_gate
  task automatic t_misc();
    wr(8'h30, 32'h6);
    wr(8'h34, 32'h5);
    wr(8'h38, 32'h1);
    wr(8'h3C, 32'hA);
    wr(ADDR_START, 32'hC);
    repeat (3) begin
      lvl <= 5'h0A;
      repeat (6) @(posedge mclk);
      lvl <= 5'h02;
      repeat (6) @(posedge mclk);
    end
    rd(ADDR_START);
    chk("oneshot_halt", 32'h8, q);
    rd(8'h34);
    chk("oneshot_zero", 32'h0, q);
    chk("oneshot_pin", 32'h1, pout[2]);
    rd(8'h3C);
    chk("events", 32'h7, q);
    wr(ADDR_PORT_OUT, 32'h1A);
    @(posedge mclk);
    chk("port_out", 32'h1A, {27'h0, pout[4:3], 1'b0, pout[1], 1'b0});
  endtask : t_misc
  task automatic t_chain();
    wr(8'h28, 32'h0);
    wr(8'h2C, 32'h1);
    wr(8'h30, 32'h21);
    wr(8'h34, 32'h64);
    // back-to-back writes leave channel 1 ticking three times: exactly one underflow
    wr(ADDR_START, 32'h6);
    wr(ADDR_START, 32'h4);
    rd(8'h34);
    chk("chained", 32'h63, q);
    wr(ADDR_START, 32'h0);
  endtask : t_chain
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_period();
    t_irq();
    t_run();
    t_gate();
    t_misc();
    t_chain();
    summarize();
  end
endmodule : tb_top
